// ===== core/astx_defines.svh
`ifndef ASTX_DEFINES_SVH
`define ASTX_DEFINES_SVH
// Register byte offsets
`define ASTX_OFF_DATA 6'h00
`define ASTX_OFF_IER 6'h04
`define ASTX_OFF_IIR 6'h08
`define ASTX_OFF_LCR 6'h0C
`define ASTX_OFF_LSR 6'h10
`define ASTX_OFF_DIV 6'h14
`define ASTX_OFF_SRC 6'h18
// Reset values
`define ASTX_LCR_RST 6'h03
`define ASTX_DIV_RST 16'h0001
// Field positions
`define ASTX_FCR_EN 0
`define ASTX_FCR_RXRST 1
`define ASTX_FCR_TXRST 2
// Clock figures in MHz; source ticks come from a fractional accumulator
`define ASTX_CLK_MHZ 7'd100
`define ASTX_SRC_HI_MHZ 7'd24
`define ASTX_SRC_LO_MHZ 7'd16
// Oversampling and frame timing, in baud16 ticks; FIFO depth in entries
`define ASTX_OVS 6'd16
`define ASTX_MID 6'd8
`define ASTX_STOP15 6'd24
`define ASTX_STOP2 6'd32
`define ASTX_FILT 2'd2
`define ASTX_DEPTH 5'd16
// Interrupt identity codes
`define ASTX_IIR_LINE 4'h6
`define ASTX_IIR_RDA 4'h4
`define ASTX_IIR_THRE 4'h2
`define ASTX_IIR_NONE 4'h1
`endif

// ===== core/astx_pkg.sv
package astx_pkg;
    // Line control fields
    typedef struct packed {
        logic sticky;
        logic even;
        logic par_en;
        logic stop2;
        logic [1:0] wlen;
    } astx_lcr_type;
    typedef enum logic [2:0] {
        FR_IDLE = 3'b000,
        FR_START = 3'b001,
        FR_DATA = 3'b010,
        FR_PAR = 3'b011,
        FR_STOP = 3'b100
    } astx_frame_type;
endpackage

// ===== core/astx_uart.sv
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "astx_defines.svh"
// Functional notes
// - Baud source is a 24 MHz or 16 MHz tick, chosen by software.
// - 24 MHz source covers standard rates 50 baud to 115.2 kilobaud.
// - 16 MHz source covers 125 to 1000 kilobaud.
// - Character has one start bit and five to eight data bits.
// - Stop bits are one, one and a half, or two bit periods.
// - Parity is even, odd, sticky or absent.
// - Source is divided by a 16-bit divisor from 1 to 65535.
// - Writing the holding register or FIFO starts transmission.
// - Character loads into shifter with start, parity and stop framing.
// - Line order: start, data LSB first, parity, stop.
// - Each bit lasts sixteen baud generator outputs.
// - Holding-register-empty interrupt fires when holding register or FIFO empties.
// - FIFO control bit 0 enables sixteen-byte queueing.
// - In FIFO mode characters go back to back until the FIFO drains.
// - Highest-priority pending interrupt is the one reported.
// - Divisor settings reach the MIDI rate as well.
// - Receiver samples at baud16 and rejects glitches under two periods.
// - Receive data interrupt fires at trigger level 1, 4, 8 or 14.
// - Receiver checks parity and stop bits, flags parity and framing errors.
module astx_uart (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rxd,
    output logic txd,
    output logic irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] nbits(input logic [1:0] w);
        nbits = 4'd5 + {2'b00, w};
    endfunction
    function automatic logic par_of(input astx_pkg::astx_lcr_type l, input logic [7:0] d);
        par_of = l.sticky ? ~l.even : (l.even ? ^d : ~^d);
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    astx_pkg::astx_lcr_type lcr_reg;
    logic [3:0] ier_reg;
    logic fifo_en_reg;
    logic [1:0] trig_sel_reg;
    logic [15:0] div_reg;
    logic src_lo_reg;
    logic pe_reg, fe_reg, oe_reg, thre_pend_reg;
    logic wr_pend_reg;
    logic [5:0] wr_addr_reg;

    // Bus decode, zero wait states; reads are sampled in the address phase
    wire addr_ok = hsel & hready & htrans[1];
    wire rd_go = addr_ok & ~hwrite;
    wire [5:0] ra = haddr[5:0];
    wire wr_do = wr_pend_reg;
    wire wr_data = wr_do & (wr_addr_reg == `ASTX_OFF_DATA);
    wire wr_ier = wr_do & (wr_addr_reg == `ASTX_OFF_IER);
    wire wr_fcr = wr_do & (wr_addr_reg == `ASTX_OFF_IIR);
    wire wr_lcr = wr_do & (wr_addr_reg == `ASTX_OFF_LCR);
    wire wr_div = wr_do & (wr_addr_reg == `ASTX_OFF_DIV);
    wire wr_src = wr_do & (wr_addr_reg == `ASTX_OFF_SRC);
    wire rd_data = rd_go & (ra == `ASTX_OFF_DATA);
    wire rd_iir = rd_go & (ra == `ASTX_OFF_IIR);
    wire rd_lsr = rd_go & (ra == `ASTX_OFF_LSR);
    wire fifo_chg = wr_fcr & (hwdata[`ASTX_FCR_EN] != fifo_en_reg);
    wire tx_clr = wr_fcr & (hwdata[`ASTX_FCR_TXRST] | fifo_chg);
    wire rx_clr = wr_fcr & (hwdata[`ASTX_FCR_RXRST] | fifo_chg);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture for writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 6'h00;
        end else begin
            wr_pend_reg <= addr_ok & hwrite;
            wr_addr_reg <= haddr[5:0];
        end
    end

    // Control registers written in the data phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lcr_reg <= `ASTX_LCR_RST;
            ier_reg <= 4'h0;
            fifo_en_reg <= 1'b0;
            trig_sel_reg <= 2'b00;
            div_reg <= `ASTX_DIV_RST;
            src_lo_reg <= 1'b0;
        end else begin
            if (wr_lcr) lcr_reg <= hwdata[5:0];
            if (wr_ier) ier_reg <= hwdata[3:0];
            if (wr_fcr) begin
                fifo_en_reg <= hwdata[`ASTX_FCR_EN];
                trig_sel_reg <= hwdata[7:6];
            end
            if (wr_div) div_reg <= hwdata[15:0];
            if (wr_src) src_lo_reg <= hwdata[0];
        end
    end

    // ----------------------------------------
    // Baud generator
    // ----------------------------------------
    // Source clock is emulated as an average-rate tick from the system clock
    logic [6:0] acc_reg;
    logic [15:0] dcnt_reg;
    wire [6:0] src_inc = src_lo_reg ? `ASTX_SRC_LO_MHZ : `ASTX_SRC_HI_MHZ;
    wire [6:0] acc_sum = acc_reg + src_inc;
    wire src_tick = acc_sum >= `ASTX_CLK_MHZ;
    wire [15:0] div_eff = (div_reg == 16'h0000) ? 16'h0001 : div_reg;
    wire baud16 = src_tick & (dcnt_reg >= div_eff - 16'h0001);
    // Any divisor, so MIDI and the 24/16 MHz rate tables are all reachable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_reg <= 7'h00;
            dcnt_reg <= 16'h0000;
        end else begin
            acc_reg <= src_tick ? acc_sum - `ASTX_CLK_MHZ : acc_sum;
            if (src_tick) dcnt_reg <= baud16 ? 16'h0000 : dcnt_reg + 16'h0001;
        end
    end

    // ----------------------------------------
    // Transmit FIFO and shifter
    // ----------------------------------------
    logic [7:0] tx_mem [0:15];
    logic [3:0] tx_wp_reg, tx_rp_reg;
    logic [4:0] tx_cnt_reg;
    astx_pkg::astx_frame_type tx_st_reg;
    logic [5:0] tx_tk_reg;
    logic [2:0] tx_bit_reg;
    logic [7:0] tx_sh_reg;
    logic tx_par_reg;
    logic txd_reg;
    wire [4:0] cap = fifo_en_reg ? `ASTX_DEPTH : 5'd1;
    wire tx_push = wr_data & (tx_cnt_reg < cap);
    wire tx_end_bit = baud16 & (tx_tk_reg == `ASTX_OVS - 6'd1);
    wire [5:0] stop_len = !lcr_reg.stop2 ? `ASTX_OVS : (lcr_reg.wlen == 2'b00 ? `ASTX_STOP15 : `ASTX_STOP2);
    wire tx_end_stop = baud16 & (tx_tk_reg == stop_len - 6'd1);
    // Next character starts on the last stop tick, so queued frames leave with no idle gap
    wire tx_load = (tx_cnt_reg != 5'd0) & (((tx_st_reg == astx_pkg::FR_IDLE) & baud16) |
                   ((tx_st_reg == astx_pkg::FR_STOP) & tx_end_stop));
    wire [7:0] tx_head = tx_mem[tx_rp_reg];
    wire [7:0] tx_mask = 8'hFF >> (4'd8 - nbits(lcr_reg.wlen));

    always_ff @(posedge clk) begin
        if (tx_push) tx_mem[tx_wp_reg] <= hwdata[7:0];
    end

    // FIFO pointers; a single-entry depth stands in for the holding register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_wp_reg <= 4'h0;
            tx_rp_reg <= 4'h0;
            tx_cnt_reg <= 5'd0;
        end else if (tx_clr) begin
            tx_wp_reg <= 4'h0;
            tx_rp_reg <= 4'h0;
            tx_cnt_reg <= 5'd0;
        end else begin
            if (tx_push) tx_wp_reg <= tx_wp_reg + 4'h1;
            if (tx_load) tx_rp_reg <= tx_rp_reg + 4'h1;
            tx_cnt_reg <= tx_cnt_reg + {4'h0, tx_push} - {4'h0, tx_load};
        end
    end

    // Frame sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_reg <= astx_pkg::FR_IDLE;
            tx_tk_reg <= 6'd0;
            tx_bit_reg <= 3'd0;
            tx_sh_reg <= 8'h00;
            tx_par_reg <= 1'b0;
            txd_reg <= 1'b1;
        end else begin
            if (baud16) tx_tk_reg <= tx_tk_reg + 6'd1;
            case (tx_st_reg)
                astx_pkg::FR_IDLE: txd_reg <= 1'b1;
                astx_pkg::FR_START: begin
                    if (tx_end_bit) begin
                        tx_st_reg <= astx_pkg::FR_DATA;
                        tx_tk_reg <= 6'd0;
                        tx_bit_reg <= 3'd0;
                        txd_reg <= tx_sh_reg[0];
                    end
                end
                astx_pkg::FR_DATA: begin
                    if (tx_end_bit) begin
                        tx_tk_reg <= 6'd0;
                        tx_sh_reg <= tx_sh_reg >> 1;
                        tx_bit_reg <= tx_bit_reg + 3'd1;
                        txd_reg <= tx_sh_reg[1];
                        if ({1'b0, tx_bit_reg} == nbits(lcr_reg.wlen) - 4'd1) begin
                            tx_st_reg <= lcr_reg.par_en ? astx_pkg::FR_PAR : astx_pkg::FR_STOP;
                            txd_reg <= lcr_reg.par_en ? tx_par_reg : 1'b1;
                        end
                    end
                end
                astx_pkg::FR_PAR: begin
                    if (tx_end_bit) begin
                        tx_st_reg <= astx_pkg::FR_STOP;
                        tx_tk_reg <= 6'd0;
                        txd_reg <= 1'b1;
                    end
                end
                astx_pkg::FR_STOP: begin
                    if (tx_end_stop) begin
                        tx_st_reg <= astx_pkg::FR_IDLE;
                        tx_tk_reg <= 6'd0;
                    end
                end
                default: tx_st_reg <= astx_pkg::FR_IDLE;
            endcase
            // Load overrides the state step, from idle or from the end of a stop bit
            if (tx_load) begin
                tx_sh_reg <= tx_head & tx_mask;
                tx_par_reg <= par_of(lcr_reg, tx_head & tx_mask);
                tx_st_reg <= astx_pkg::FR_START;
                tx_tk_reg <= 6'd0;
                txd_reg <= 1'b0;
            end
        end
    end
    assign txd = txd_reg;

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    logic rx_s1_reg, rx_s2_reg, rx_f_reg;
    logic [1:0] rx_gl_reg;
    astx_pkg::astx_frame_type rx_st_reg;
    logic [5:0] rx_tk_reg;
    logic [2:0] rx_bit_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] rx_mem [0:15];
    logic [3:0] rx_wp_reg, rx_rp_reg;
    logic [4:0] rx_cnt_reg;
    wire [7:0] rx_word = rx_sh_reg >> (4'd8 - nbits(lcr_reg.wlen));
    wire rx_mid = baud16 & (rx_tk_reg == `ASTX_OVS - 6'd1);
    wire rx_done = rx_mid & (rx_st_reg == astx_pkg::FR_STOP);
    wire rx_full = rx_cnt_reg >= cap;
    wire rx_push = rx_done & ~rx_full;
    wire rx_pop = rd_data & (rx_cnt_reg != 5'd0);
    wire pe_set = rx_st_reg == astx_pkg::FR_PAR && rx_mid && rx_f_reg != par_of(lcr_reg, rx_word);
    wire fe_set = rx_done & ~rx_f_reg;

    // Two-stage synchroniser, then a filter that needs two steady baud16 samples
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_f_reg <= 1'b1;
            rx_gl_reg <= 2'd0;
        end else begin
            rx_s1_reg <= rxd;
            rx_s2_reg <= rx_s1_reg;
            if (baud16) begin
                rx_gl_reg <= (rx_s2_reg == rx_f_reg) ? 2'd0 : rx_gl_reg + 2'd1;
                if (rx_s2_reg != rx_f_reg && rx_gl_reg == `ASTX_FILT - 2'd1) rx_f_reg <= rx_s2_reg;
            end
        end
    end

    // Frame capture; samples are taken mid-bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_reg <= astx_pkg::FR_IDLE;
            rx_tk_reg <= 6'd0;
            rx_bit_reg <= 3'd0;
            rx_sh_reg <= 8'h00;
        end else begin
            if (baud16) rx_tk_reg <= rx_tk_reg + 6'd1;
            case (rx_st_reg)
                astx_pkg::FR_IDLE: if (baud16 & ~rx_f_reg) begin
                    rx_st_reg <= astx_pkg::FR_START;
                    rx_tk_reg <= `ASTX_MID;
                end
                astx_pkg::FR_START: if (rx_mid) begin
                    rx_tk_reg <= 6'd0;
                    rx_bit_reg <= 3'd0;
                    rx_st_reg <= rx_f_reg ? astx_pkg::FR_IDLE : astx_pkg::FR_DATA;
                end
                astx_pkg::FR_DATA: if (rx_mid) begin
                    rx_tk_reg <= 6'd0;
                    rx_sh_reg <= {rx_f_reg, rx_sh_reg[7:1]};
                    rx_bit_reg <= rx_bit_reg + 3'd1;
                    if ({1'b0, rx_bit_reg} == nbits(lcr_reg.wlen) - 4'd1)
                        rx_st_reg <= lcr_reg.par_en ? astx_pkg::FR_PAR : astx_pkg::FR_STOP;
                end
                astx_pkg::FR_PAR: if (rx_mid) begin
                    rx_tk_reg <= 6'd0;
                    rx_st_reg <= astx_pkg::FR_STOP;
                end
                astx_pkg::FR_STOP: if (rx_mid) rx_st_reg <= astx_pkg::FR_IDLE;
                default: rx_st_reg <= astx_pkg::FR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rx_push) rx_mem[rx_wp_reg] <= rx_word;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_wp_reg <= 4'h0;
            rx_rp_reg <= 4'h0;
            rx_cnt_reg <= 5'd0;
        end else if (rx_clr) begin
            rx_wp_reg <= 4'h0;
            rx_rp_reg <= 4'h0;
            rx_cnt_reg <= 5'd0;
        end else begin
            if (rx_push) rx_wp_reg <= rx_wp_reg + 4'h1;
            if (rx_pop) rx_rp_reg <= rx_rp_reg + 4'h1;
            rx_cnt_reg <= rx_cnt_reg + {4'h0, rx_push} - {4'h0, rx_pop};
        end
    end

    // ----------------------------------------
    // Status and interrupt identity
    // ----------------------------------------
    wire [4:0] trig_lvl = !fifo_en_reg ? 5'd1 : (trig_sel_reg == 2'd0 ? 5'd1 : trig_sel_reg == 2'd1 ? 5'd4 :
                          trig_sel_reg == 2'd2 ? 5'd8 : 5'd14);
    wire line_irq = ier_reg[2] & (pe_reg | fe_reg | oe_reg);
    wire rda_irq = ier_reg[0] & (rx_cnt_reg >= trig_lvl);
    wire thre_irq = ier_reg[1] & thre_pend_reg;
    wire [3:0] iir_id = line_irq ? `ASTX_IIR_LINE : rda_irq ? `ASTX_IIR_RDA :
                        thre_irq ? `ASTX_IIR_THRE : `ASTX_IIR_NONE;
    wire tx_empties = (tx_cnt_reg != 5'd0) & (tx_cnt_reg + {4'h0, tx_push} - {4'h0, tx_load} == 5'd0);
    wire tx_idle = (tx_cnt_reg == 5'd0) & (tx_st_reg == astx_pkg::FR_IDLE);
    wire [7:0] lsr = {1'b0, tx_idle, tx_cnt_reg == 5'd0, 1'b0, fe_reg, pe_reg, oe_reg, rx_cnt_reg != 5'd0};
    wire [31:0] rd_mux = (ra == `ASTX_OFF_DATA) ? {24'h0, rx_mem[rx_rp_reg]} :
                         (ra == `ASTX_OFF_IER) ? {28'h0, ier_reg} :
                         (ra == `ASTX_OFF_IIR) ? {24'h0, {2{fifo_en_reg}}, 2'b00, iir_id} :
                         (ra == `ASTX_OFF_LCR) ? {26'h0, lcr_reg} :
                         (ra == `ASTX_OFF_LSR) ? {24'h0, lsr} :
                         (ra == `ASTX_OFF_DIV) ? {16'h0, div_reg} :
                         (ra == `ASTX_OFF_SRC) ? {31'h0, src_lo_reg} : 32'h0;

    // Sticky flags; a set in the same cycle as its clearing read wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pe_reg <= 1'b0;
            fe_reg <= 1'b0;
            oe_reg <= 1'b0;
            thre_pend_reg <= 1'b0;
            hrdata <= 32'h0;
        end else begin
            pe_reg <= pe_set | (pe_reg & ~rd_lsr);
            fe_reg <= fe_set | (fe_reg & ~rd_lsr);
            oe_reg <= (rx_done & rx_full) | (oe_reg & ~rd_lsr);
            thre_pend_reg <= tx_empties | (thre_pend_reg & ~(wr_data | (rd_iir & iir_id == `ASTX_IIR_THRE)));
            if (rd_go) hrdata <= rd_mux;
        end
    end
    assign irq = line_irq | rda_irq | thre_irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_stop_done;
        tx_st_reg == astx_pkg::FR_STOP && tx_end_stop;
    endsequence
    a_start_low: assert property (@(posedge clk) disable iff (!rst_b)
        tx_st_reg == astx_pkg::FR_START |-> txd == 1'b0) else $error("start bit not low");
    a_stop_high: assert property (@(posedge clk) disable iff (!rst_b)
        tx_st_reg == astx_pkg::FR_STOP |-> txd == 1'b1) else $error("stop bit not high");
    a_bit_hold: assert property (@(posedge clk) disable iff (!rst_b)
        tx_st_reg == astx_pkg::FR_DATA && !tx_end_bit |=> $stable(txd)) else $error("data bit changed early");
    a_par_value: assert property (@(posedge clk) disable iff (!rst_b)
        tx_st_reg == astx_pkg::FR_PAR |-> txd == tx_par_reg) else $error("wrong parity bit");
    a_src_spacing: assert property (@(posedge clk) disable iff (!rst_b)
        src_tick |=> !src_tick ##1 !src_tick) else $error("source tick too fast");
    a_fifo_cap: assert property (@(posedge clk) disable iff (!rst_b)
        tx_cnt_reg <= cap || $past(fifo_en_reg)) else $error("tx queue over capacity");
    a_thre_event: assert property (@(posedge clk) disable iff (!rst_b)
        tx_empties && !tx_clr |=> thre_pend_reg) else $error("empty event lost");
    a_back_to_back: assert property (@(posedge clk) disable iff (!rst_b)
        s_stop_done ##0 (tx_cnt_reg != 5'd0 && !tx_clr) |=> tx_st_reg == astx_pkg::FR_START)
        else $error("queued character not sent");
    a_iir_prio: assert property (@(posedge clk) disable iff (!rst_b)
        line_irq |-> iir_id == `ASTX_IIR_LINE && irq) else $error("line status not top priority");
    a_rx_trigger: assert property (@(posedge clk) disable iff (!rst_b)
        ier_reg[0] && fifo_en_reg && trig_sel_reg == 2'd3 && rx_cnt_reg == 5'd13 |-> !rda_irq)
        else $error("receive trigger early");
endmodule

// ===== dv/astx_serial_peer.sv
`timescale 1ns/1ps
// ----------------------------
// Far-side serial device model
// ----------------------------
module astx_serial_peer (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    int nbits = 10; // Samples per frame, start and stop included
    int bit_clk = 100; // 16 MHz source, divisor 1
    logic [11:0] got[$];
    realtime t_first = 0.0;
    realtime t_last = 0.0;
    // Mid-bit sampling; a half stop bit is never sampled, so 1.5 reads as 1
    initial begin
        logic [11:0] f;
        forever begin
            @(negedge txd);
            if (got.size() == 0) t_first = $realtime;
            t_last = $realtime;
            f = 12'hFFF;
            repeat (bit_clk / 2) @(posedge clk);
            for (int i = 0; i < nbits; i++) begin
                f[i] = txd;
                if (i < nbits - 1) repeat (bit_clk) @(posedge clk);
            end
            got.push_back(f);
        end
    end
    initial rxd = 1'b1; // Line idles high
    // Sends bit 0 first; faulty parity or stop bits come from the caller
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (bit_clk) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
`include "astx_defines.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, txd, rxd, irq;
    logic [31:0] hrdata;
    logic [31:0] rv;
    logic [11:0] fr;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;
    localparam logic [5:0] LCRS [0:6] = '{6'h03, 6'h00, 6'h1A, 6'h0D, 6'h3B, 6'h2B, 6'h04};
    localparam logic [7:0] DATS [0:6] = '{8'hA5, 8'h17, 8'h5D, 8'h33, 8'h81, 8'h81, 8'h0B};

    always #5 clk = ~clk;
    astx_uart DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rxd(rxd), .txd(txd), .irq(irq));
    astx_serial_peer PEER (.clk(clk), .txd(txd), .rxd(rxd));

    // ---------------
    // Bus and helpers
    // ---------------
    task automatic bus_wait();
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {26'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        bus_wait();
        rv = hrdata;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rv & m, e)
    endtask
    task automatic wait_frames(input int k);
        while (PEER.got.size() < k) @(posedge clk);
    endtask
    // Expected line image: start, data LSB first, parity, whole stop bits
    function automatic logic [11:0] frame(input logic [5:0] lcr, input logic [7:0] d);
        logic [11:0] f;
        int w;
        f = 12'hFFF;
        w = 5 + int'(lcr[1:0]);
        f[0] = 1'b0;
        for (int i = 0; i < w; i++) f[1 + i] = d[i];
        n = 1 + w;
        if (lcr[3]) begin
            f[n] = lcr[5] ? ~lcr[4] : (^(d & ~(8'hFF << w))) ^ ~lcr[4];
            n++;
        end
        n += (lcr[2] && w != 5) ? 2 : 1;
        return f;
    endfunction
    // One character, line idle before and after; LCR is never changed mid-frame
    task automatic tx_one(input logic [5:0] lcr, input logic [7:0] d);
        realtime t0;
        fr = frame(lcr, d);
        wr(`ASTX_OFF_LCR, {26'h0, lcr});
        PEER.nbits = n;
        PEER.got.delete();
        wr(`ASTX_OFF_DATA, {24'h0, d});
        @(negedge txd);
        t0 = $realtime;
        @(posedge txd);
        `CHK(($realtime - t0) > 980.0 && ($realtime - t0) < 1020.0, 1'b1)
        wait_frames(1);
        `CHK(PEER.got[0], fr)
        repeat (100) @(posedge clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Hang guard, about twice the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            conclude();
        end
    end

    // ---------
    // Sequences
    // ---------
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(`ASTX_OFF_LCR, 32'hFF, {26'h0, `ASTX_LCR_RST});
        rd_chk(`ASTX_OFF_DIV, 32'hFFFF, {16'h0, `ASTX_DIV_RST});
        rd_chk(`ASTX_OFF_IIR, 32'hF, {28'h0, `ASTX_IIR_NONE});
        rd_chk(`ASTX_OFF_LSR, 32'h60, 32'h60);
        rd_chk(6'h1C, 32'hFFFFFFFF, 32'h0);
        wr(`ASTX_OFF_DIV, 32'hFFFF);
        rd_chk(`ASTX_OFF_DIV, 32'hFFFF, 32'hFFFF);
        wr(`ASTX_OFF_DIV, 32'h1);
        wr(`ASTX_OFF_SRC, 32'h1);
        $display("registers done");
        for (int i = 0; i < 7; i++) tx_one(LCRS[i], DATS[i]);
        $display("frames done");
        wr(`ASTX_OFF_IIR, 32'h1 << `ASTX_FCR_EN);
        wr(`ASTX_OFF_IER, 32'h2);
        wr(`ASTX_OFF_LCR, 32'h3);
        PEER.nbits = 10;
        PEER.got.delete();
        for (int i = 0; i < 16; i++) wr(`ASTX_OFF_DATA, 32'h30 + 32'(i));
        wait_frames(16);
        for (int i = 0; i < 16; i++) `CHK(PEER.got[i], frame(6'h03, 8'(8'h30 + i)))
        `CHK((PEER.t_last - PEER.t_first) > 149970.0 && (PEER.t_last - PEER.t_first) < 150030.0, 1'b1)
        repeat (150) @(posedge clk);
        `CHK(irq, 1'b1)
        rd_chk(`ASTX_OFF_IIR, 32'hF, {28'h0, `ASTX_IIR_THRE});
        rd_chk(`ASTX_OFF_IIR, 32'hF, {28'h0, `ASTX_IIR_NONE});
        `CHK(irq, 1'b0)
        rd_chk(`ASTX_OFF_LSR, 32'h60, 32'h60);
        $display("fifo done");
        wr(`ASTX_OFF_IIR, 32'h0);
        wr(`ASTX_OFF_IER, 32'h1);
        fr = frame(6'h03, 8'h3C);
        PEER.send(fr, n);
        repeat (20) @(posedge clk);
        `CHK(irq, 1'b1)
        rd_chk(`ASTX_OFF_IIR, 32'hF, {28'h0, `ASTX_IIR_RDA});
        rd_chk(`ASTX_OFF_DATA, 32'hFF, 32'h3C);
        rd_chk(`ASTX_OFF_LSR, 32'h1, 32'h0);
        wr(`ASTX_OFF_LCR, 32'h1B);
        fr = frame(6'h1B, 8'h3C);
        PEER.send(fr ^ 12'h200, n); // Parity bit flipped
        repeat (20) @(posedge clk);
        rd_chk(`ASTX_OFF_LSR, 32'hC, 32'h4);
        rd_chk(`ASTX_OFF_DATA, 32'hFF, 32'h3C);
        PEER.send(fr & 12'hBFF, n); // Stop bit low
        repeat (20) @(posedge clk);
        rd_chk(`ASTX_OFF_LSR, 32'hC, 32'h8);
        $display("receive done");
        conclude();
    end
endmodule
